// *** hw/asrb_core.v ***
`timescale 1ns/1ps
// Notes on behaviour
// - receive line sampled by x16 oversampler
// - bit rate from 8-bit divisor, or 16-bit in wide mode, speed bits
// - nine-bit mode shows ninth bit in status
// - frame end sets flag, irq if enabled
// - eight data bits out, errors in status
// - clearing continuous receive clears latched errors
// - irq needs global and peripheral enables
// - receive irq priority select provided
// - address detect filters in nine-bit mode; cleared passes all bytes
// - break is start, twelve zeros, stop
// - send break with transmit enable, zeros sent
// - hardware clears send break after stop
// - next byte accepted during break, sent after
// - shift empty status tracks break like frames
// - transmit buffer empty flag when buffer empties
// - auto-wake catches two edges, then byte
module asrb_core (
	// clock and reset
	input  wire        clk,
	input  wire        rst,
	// baud configuration
	input  wire [7:0]  baud_divisor_high,
	input  wire [7:0]  baud_divisor_low,
	input  wire        high_speed_baud_select,
	input  wire        wide_divisor_mode,
	// port control
	input  wire        serial_port_enable,
	input  wire        nine_bit_receive_enable,
	input  wire        continuous_receive_enable,
	input  wire        address_detect_enable,
	input  wire        auto_wake_enable,
	// interrupt control
	input  wire        receive_irq_enable,
	input  wire        receive_irq_priority,
	input  wire        global_irq_enable,
	input  wire        peripheral_irq_enable,
	// receive buffer read
	input  wire        receive_data_read,
	output reg  [7:0]  receive_data_register,
	output reg         receive_ninth_bit,
	output reg         framing_error,
	output reg         overrun_error,
	output reg         receive_complete_flag,
	output wire        receive_irq_high,
	output wire        receive_irq_low,
	// transmit side
	input  wire        transmit_enable_bit,
	input  wire        send_break_set,
	input  wire        transmit_write,
	input  wire [7:0]  transmit_data_register,
	input  wire        transmit_ninth_bit,
	input  wire        nine_bit_transmit_enable,
	output reg         send_break_request,
	output reg         transmit_buffer_empty_flag,
	output reg         shift_register_empty,
	// serial pins
	input  wire        rx_pin,
	output reg         tx_pin
);
`include "asrb_defs.vh"

// ****************************************************************
// shared helpers
// ****************************************************************
	// frame length in data bits for the current settings
	function [3:0] data_bits;
		input nine;
		begin
			data_bits = nine ? `ASRB_NINE_BITS : `ASRB_BYTE_BITS;
		end
	endfunction

	wire tick;
	asrb_baud_gen u_baud (
		.clk                    (clk),
		.rst                    (rst),
		.divisor                ({baud_divisor_high, baud_divisor_low}),
		.high_speed_baud_select (high_speed_baud_select),
		.wide_divisor_mode      (wide_divisor_mode),
		.enable                 (serial_port_enable),
		.tick_x16               (tick)
	);

// ****************************************************************
// receive pin synchroniser and oversampler
// ****************************************************************
	reg        rx_meta_r;
	reg        rx_sync_r;
	// only the second stage feeds logic; the first may be metastable
	always @(posedge clk) begin
		if (rst) begin
			rx_meta_r <= `ASRB_RX_IDLE;
			rx_sync_r <= `ASRB_RX_IDLE;
		end else begin
			rx_meta_r <= rx_pin;
			rx_sync_r <= rx_meta_r;
		end
	end

	localparam RX_IDLE  = 2'd0;
	localparam RX_START = 2'd1;
	localparam RX_DATA  = 2'd2;
	localparam RX_STOP  = 2'd3;

	reg [1:0]  rx_state_r;
	reg [3:0]  rx_ovs_r;
	reg [3:0]  rx_bit_r;
	reg [8:0]  rx_shift_r;
	reg        rx_prev_r;
	reg [1:0]  wake_edges_r;
	reg        wake_armed_r;
	reg        rx_done;
	reg        rx_stop_ok;
	reg        wake_event;
	wire       rx_run;
	wire       rx_accept;

	assign rx_run = serial_port_enable && continuous_receive_enable;

	// address filter: with detect on in nine-bit mode only frames
	// whose ninth bit is set get through
	assign rx_accept = !(address_detect_enable && nine_bit_receive_enable
		&& !rx_shift_r[8]);

	always @(posedge clk) begin
		if (rst || !rx_run) begin
			rx_state_r <= RX_IDLE;
			rx_ovs_r   <= 4'h0;
			rx_bit_r   <= 4'h0;
			rx_shift_r <= 9'h000;
			rx_done    <= 1'b0;
			rx_stop_ok <= 1'b0;
		end else begin
			rx_done <= 1'b0;
			if (tick) begin
				rx_ovs_r <= rx_ovs_r + 4'h1;
				case (rx_state_r)
				RX_IDLE: begin
					rx_ovs_r <= 4'h0;
					if (!rx_sync_r && !wake_armed_r)
						rx_state_r <= RX_START;
				end
				RX_START: begin
					// mid-bit check rejects glitches shorter than half a bit
					if (rx_ovs_r == `ASRB_OVS_MID) begin
						rx_ovs_r <= 4'h0;
						rx_bit_r <= 4'h0;
						rx_state_r <= rx_sync_r ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (rx_ovs_r == 4'hf) begin
						rx_shift_r <= nine_bit_receive_enable ?
							{rx_sync_r, rx_shift_r[8:1]} :
							{1'b0, rx_sync_r, rx_shift_r[7:1]};
						rx_bit_r <= rx_bit_r + 4'h1;
						if (rx_bit_r + 4'h1 ==
							data_bits(nine_bit_receive_enable))
							rx_state_r <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (rx_ovs_r == 4'hf) begin
						rx_stop_ok <= rx_sync_r;
						rx_done    <= 1'b1;
						rx_state_r <= RX_IDLE;
					end
				end
				default: rx_state_r <= RX_IDLE;
				endcase
			end
		end
	end

	// auto-wake: the second of two line edges raises one receive event,
	// the following byte is then received normally
	always @(posedge clk) begin
		if (rst) begin
			rx_prev_r    <= `ASRB_RX_IDLE;
			wake_edges_r <= 2'd0;
			wake_armed_r <= 1'b0;
			wake_event   <= 1'b0;
		end else begin
			rx_prev_r  <= rx_sync_r;
			wake_event <= 1'b0;
			if (!auto_wake_enable || !serial_port_enable) begin
				wake_armed_r <= auto_wake_enable && serial_port_enable;
				wake_edges_r <= 2'd0;
			end else if (wake_armed_r && rx_prev_r != rx_sync_r) begin
				wake_edges_r <= wake_edges_r + 2'd1;
				if (wake_edges_r == 2'd1) begin
					wake_armed_r <= 1'b0;
					wake_event   <= 1'b1;
				end
			end else if (!wake_armed_r && wake_edges_r == 2'd0) begin
				wake_armed_r <= 1'b1;
			end
		end
	end

// ****************************************************************
// receive buffer, flags and errors
// ****************************************************************
	always @(posedge clk) begin
		if (rst) begin
			receive_data_register <= 8'h00;
			receive_ninth_bit     <= 1'b0;
			framing_error         <= 1'b0;
			overrun_error         <= 1'b0;
			receive_complete_flag <= 1'b0;
		end else begin
			if (receive_data_read)
				receive_complete_flag <= 1'b0;
			// clearing continuous receive drops latched errors
			if (!continuous_receive_enable) begin
				framing_error <= 1'b0;
				overrun_error <= 1'b0;
			end
			if (wake_event)
				receive_complete_flag <= 1'b1;
			// a new frame wins over a read in the same cycle
			if (rx_done && rx_accept) begin
				// overrun keeps the older byte, which the host has not seen
				if (receive_complete_flag && !receive_data_read) begin
					overrun_error <= 1'b1;
				end else begin
					receive_data_register <= rx_shift_r[7:0];
					receive_ninth_bit     <= rx_shift_r[8];
					framing_error         <= !rx_stop_ok;
					receive_complete_flag <= 1'b1;
				end
			end
		end
	end

// ****************************************************************
// interrupt requests
// ****************************************************************
	wire rx_irq;
	assign rx_irq = receive_complete_flag && receive_irq_enable
		&& global_irq_enable && peripheral_irq_enable;
	assign receive_irq_high = rx_irq && receive_irq_priority;
	assign receive_irq_low  = rx_irq && !receive_irq_priority;

// ****************************************************************
// transmitter
// ****************************************************************
	reg [7:0]  tx_buf_r;
	reg        tx_buf_nine_r;
	reg        tx_buf_brk_r;
	reg [10:0] tx_shift_r;
	reg [3:0]  tx_ovs_r;
	reg [3:0]  tx_left_r;
	reg        tx_brk_r;
	wire       tx_load;
	wire       tx_bit_end;

	// load only once the last frame has fully left the shifter
	assign tx_load = !transmit_buffer_empty_flag && shift_register_empty
		&& transmit_enable_bit && serial_port_enable;
	assign tx_bit_end = tick && tx_ovs_r == 4'hf;

// ****************************************************************
// transmit buffer and break request
// ****************************************************************

	always @(posedge clk) begin
		if (rst) begin
			tx_buf_r                   <= 8'h00;
			tx_buf_nine_r              <= 1'b0;
			tx_buf_brk_r               <= 1'b0;
			transmit_buffer_empty_flag <= 1'b1;
			send_break_request         <= 1'b0;
		end else begin
			if (send_break_set)
				send_break_request <= 1'b1;
			if (tx_load)
				transmit_buffer_empty_flag <= 1'b1;
			// buffer refills while a break shifts out
			if (transmit_write) begin
				tx_buf_r                   <= transmit_data_register;
				tx_buf_nine_r              <= transmit_ninth_bit;
				tx_buf_brk_r               <= send_break_request
					&& !tx_brk_r;
				transmit_buffer_empty_flag <= 1'b0;
			end
			// stop of the break done; a new set in that cycle wins
			if (tx_brk_r && tx_left_r == 4'h0 && tx_bit_end
				&& !send_break_set)
				send_break_request <= 1'b0;
		end
	end

// ****************************************************************
// transmit shifter
// ****************************************************************

	always @(posedge clk) begin
		if (rst) begin
			tx_shift_r           <= 11'h7ff;
			tx_ovs_r             <= 4'h0;
			tx_left_r            <= 4'h0;
			tx_brk_r             <= 1'b0;
			shift_register_empty <= 1'b1;
			tx_pin               <= `ASRB_TX_IDLE;
		end else if (tx_load) begin
			shift_register_empty <= 1'b0;
			tx_ovs_r             <= 4'h0;
			tx_brk_r             <= tx_buf_brk_r;
			if (tx_buf_brk_r) begin
				// start then twelve zeros: data ignored
				tx_shift_r <= 11'h000;
				tx_left_r  <= `ASRB_BREAK_ZEROS + 4'h1;
			end else begin
				tx_shift_r <= {1'b1, tx_buf_nine_r, tx_buf_r, 1'b0};
				tx_left_r  <= data_bits(nine_bit_transmit_enable)
					+ 4'h1;
			end
		end else if (!shift_register_empty) begin
			tx_pin <= tx_shift_r[0];
			if (tick)
				tx_ovs_r <= tx_ovs_r + 4'h1;
			if (tx_bit_end) begin
				if (tx_left_r == 4'h0) begin
					shift_register_empty <= 1'b1;
					tx_pin <= `ASRB_TX_IDLE;
				end else begin
					tx_left_r <= tx_left_r - 4'h1;
					// the last shifted position is the stop bit; a break
					// shifts zeros in so every one of its low periods holds
					tx_shift_r <= (tx_left_r == 4'h1) ? 11'h7ff :
						{!tx_brk_r, tx_shift_r[10:1]};
				end
			end
		end else begin
			tx_pin <= `ASRB_TX_IDLE;
		end
	end
endmodule

// *** hw/asrb_defs.vh ***
`ifndef ASRB_DEFS_VH
`define ASRB_DEFS_VH
// divisor scale factors for the baud generator
`define ASRB_DIV_LO_SPEED   6'd63
`define ASRB_DIV_HI_SPEED   6'd15
`define ASRB_DIV_WIDE_LO    6'd15
`define ASRB_DIV_WIDE_HI    6'd3
// oversampling: ticks per bit and mid-bit sample point
`define ASRB_OVS            5'd16
`define ASRB_OVS_MID        4'd7
// break: start plus twelve zeros, counted as data bits
`define ASRB_BREAK_ZEROS    4'd12
`define ASRB_BYTE_BITS      4'd8
`define ASRB_NINE_BITS      4'd9
// reset values
`define ASRB_RX_IDLE        1'b1
`define ASRB_TX_IDLE        1'b1
`endif

// *** hw/asrb_baud_gen.v ***
`timescale 1ns/1ps
// ****************************************************************
// baud generator: one-cycle x16 tick
// ****************************************************************
module asrb_baud_gen (
	// clock and reset
	input  wire        clk,
	input  wire        rst,
	// divisor settings
	input  wire [15:0] divisor,
	input  wire        high_speed_baud_select,
	input  wire        wide_divisor_mode,
	input  wire        enable,
	// tick out
	output reg         tick_x16
);
`include "asrb_defs.vh"
	reg  [15:0] div_cnt_r;
	reg  [5:0]  pre_cnt_r;
	reg  [5:0]  pre_max;
	wire [15:0] div_eff;

	// 8-bit divisor unless wide mode, so upper byte is ignored
	assign div_eff = wide_divisor_mode ? divisor : {8'h00, divisor[7:0]};

	// the fixed prescale makes periods of 16/4/4/1 clocks (pre_max+1),
	// and a x16 tick is given after every divisor+1 of those periods
	always @* begin
		case ({wide_divisor_mode, high_speed_baud_select})
		2'b00:   pre_max = `ASRB_DIV_LO_SPEED >> 2;
		2'b01:   pre_max = `ASRB_DIV_HI_SPEED >> 2;
		2'b10:   pre_max = `ASRB_DIV_WIDE_LO >> 2;
		default: pre_max = `ASRB_DIV_WIDE_HI >> 2;
		endcase
	end

	always @(posedge clk) begin
		if (rst || !enable) begin
			div_cnt_r <= 16'h0000;
			pre_cnt_r <= 6'h00;
			tick_x16  <= 1'b0;
		end else begin
			tick_x16 <= 1'b0;
			if (pre_cnt_r >= pre_max) begin
				pre_cnt_r <= 6'h00;
				if (div_cnt_r >= div_eff) begin
					div_cnt_r <= 16'h0000;
					tick_x16  <= 1'b1;
				end else begin
					div_cnt_r <= div_cnt_r + 16'h0001;
				end
			end else begin
				pre_cnt_r <= pre_cnt_r + 6'h01;
			end
		end
	end
endmodule

// *** verification/asrb_core_sva.sv ***
`timescale 1ns/1ps
// ****
// port checker for the serial core
// ****
module asrb_core_chk (
	// clock and reset
	input logic       clk,
	input logic       rst,
	// receive side
	input logic       continuous_receive_enable,
	input logic       receive_data_read,
	input logic [7:0] receive_data_register,
	input logic       framing_error,
	input logic       overrun_error,
	input logic       receive_complete_flag,
	// interrupt side
	input logic       receive_irq_enable,
	input logic       receive_irq_priority,
	input logic       global_irq_enable,
	input logic       peripheral_irq_enable,
	input logic       receive_irq_high,
	input logic       receive_irq_low,
	// transmit side
	input logic       send_break_set,
	input logic       transmit_write,
	input logic       send_break_request,
	input logic       transmit_buffer_empty_flag,
	input logic       shift_register_empty,
	input logic       tx_pin
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	irq_gate_a: assert property ((receive_irq_high | receive_irq_low) ==
		(receive_complete_flag & receive_irq_enable & global_irq_enable &
		peripheral_irq_enable)) else $error("irq gating wrong");
	prio_split_a: assert property (receive_irq_high |->
		receive_irq_priority && !receive_irq_low) else $error("irq level");
	rx_hold_a: assert property (receive_complete_flag && !receive_data_read
		|=> $stable(receive_data_register)) else $error("data moved");
	flag_read_a: assert property (receive_data_read |=>
		!receive_complete_flag) else $error("flag not cleared");
	err_clear_a: assert property ($fell(continuous_receive_enable) |=>
		!framing_error && !overrun_error) else $error("errors kept");
	brk_set_a: assert property (send_break_set |=>
		send_break_request) else $error("break not armed");
	brk_end_a: assert property ($fell(send_break_request) |->
		tx_pin) else $error("break cleared early");
	tbe_fall_a: assert property (transmit_write |=>
		!transmit_buffer_empty_flag) else $error("buffer flag stuck");
	busy_line_a: assert property (!tx_pin |->
		!shift_register_empty) else $error("idle shown while sending");
endmodule
bind asrb_core asrb_core_chk chk_u (
	.clk                        (clk),
	.rst                        (rst),
	.continuous_receive_enable  (continuous_receive_enable),
	.receive_data_read          (receive_data_read),
	.receive_data_register      (receive_data_register),
	.framing_error              (framing_error),
	.overrun_error              (overrun_error),
	.receive_complete_flag      (receive_complete_flag),
	.receive_irq_enable         (receive_irq_enable),
	.receive_irq_priority       (receive_irq_priority),
	.global_irq_enable          (global_irq_enable),
	.peripheral_irq_enable      (peripheral_irq_enable),
	.receive_irq_high           (receive_irq_high),
	.receive_irq_low            (receive_irq_low),
	.send_break_set             (send_break_set),
	.transmit_write             (transmit_write),
	.send_break_request         (send_break_request),
	.transmit_buffer_empty_flag (transmit_buffer_empty_flag),
	.shift_register_empty       (shift_register_empty),
	.tx_pin                     (tx_pin)
);

// *** verification/asrb_remote.sv ***
`timescale 1ns/1ps
// ****
// remote node on the serial pair
// ****
module asrb_remote #(parameter int BIT = 64) (
	// clock
	input wire clk,
	// serial pair
	input wire tx_pin,
	output logic rx_pin
);
	logic [7:0] got_byte;
	int lows;
	int frames = 0;
	initial rx_pin = 1'b1;
	task bit_out(input logic b);
		rx_pin = b;
		repeat (BIT) @(posedge clk);
		#1;
	endtask
	// stop_ok low forces a framing fault on purpose
	task send(input logic [8:0] d, input logic nine, input logic stop_ok);
		bit_out(1'b0);
		for (int i = 0; i < 9; i++)
			if (i < 8 || nine)
				bit_out(d[i]);
		bit_out(stop_ok);
		bit_out(1'b1);
	endtask
	// low-run length tells a break from a data frame
	always @(negedge tx_pin) begin : mon
		lows = 1;
		got_byte = 8'h00;
		repeat (BIT / 2) @(posedge clk);
		for (int k = 1; k < 9 || !tx_pin; k++) begin
			repeat (BIT) @(posedge clk);
			if (k < 9)
				got_byte[k-1] = tx_pin;
			if (!tx_pin && lows == k)
				lows++;
		end
		frames++;
	end
endmodule

// *** verification/async_serial_rx_break_tb.sv ***
`timescale 1ns/1ps
// ****
// bench for the serial core
// ****
module async_serial_rx_break_tb;
	localparam int DIV = 3;
	// wide high-speed mode: one tick per divisor count plus one
	localparam int BIT = 16 * (DIV + 1);
	logic clk, rst, high_speed_baud_select, wide_divisor_mode;
	logic serial_port_enable, nine_bit_receive_enable, auto_wake_enable;
	logic continuous_receive_enable, address_detect_enable;
	logic receive_irq_enable, receive_irq_priority, global_irq_enable;
	logic peripheral_irq_enable, receive_data_read, framing_error;
	logic overrun_error, receive_complete_flag, receive_irq_high;
	logic receive_irq_low, transmit_enable_bit, send_break_set;
	logic transmit_write, transmit_ninth_bit, nine_bit_transmit_enable;
	logic send_break_request, transmit_buffer_empty_flag;
	logic shift_register_empty, rx_pin, tx_pin, receive_ninth_bit;
	logic [7:0] baud_divisor_high, baud_divisor_low;
	logic [7:0] receive_data_register, transmit_data_register;
	int fail_count = 0;
	int compares = 0;
	asrb_core dut_u (
		.clk                        (clk),
		.rst                        (rst),
		.baud_divisor_high          (baud_divisor_high),
		.baud_divisor_low           (baud_divisor_low),
		.high_speed_baud_select     (high_speed_baud_select),
		.wide_divisor_mode          (wide_divisor_mode),
		.serial_port_enable         (serial_port_enable),
		.nine_bit_receive_enable    (nine_bit_receive_enable),
		.continuous_receive_enable  (continuous_receive_enable),
		.address_detect_enable      (address_detect_enable),
		.auto_wake_enable           (auto_wake_enable),
		.receive_irq_enable         (receive_irq_enable),
		.receive_irq_priority       (receive_irq_priority),
		.global_irq_enable          (global_irq_enable),
		.peripheral_irq_enable      (peripheral_irq_enable),
		.receive_data_read          (receive_data_read),
		.receive_data_register      (receive_data_register),
		.receive_ninth_bit          (receive_ninth_bit),
		.framing_error              (framing_error),
		.overrun_error              (overrun_error),
		.receive_complete_flag      (receive_complete_flag),
		.receive_irq_high           (receive_irq_high),
		.receive_irq_low            (receive_irq_low),
		.transmit_enable_bit        (transmit_enable_bit),
		.send_break_set             (send_break_set),
		.transmit_write             (transmit_write),
		.transmit_data_register     (transmit_data_register),
		.transmit_ninth_bit         (transmit_ninth_bit),
		.nine_bit_transmit_enable   (nine_bit_transmit_enable),
		.send_break_request         (send_break_request),
		.transmit_buffer_empty_flag (transmit_buffer_empty_flag),
		.shift_register_empty       (shift_register_empty),
		.rx_pin                     (rx_pin),
		.tx_pin                     (tx_pin)
	);
	asrb_remote #(.BIT(BIT)) rem_u (
		.clk    (clk),
		.tx_pin (tx_pin),
		.rx_pin (rx_pin)
	);
	always #20 clk = ~clk;
	task test_done;
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input logic [8:0] got, input logic [8:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// sel 0 receive flag, 1 buffer empty, n>1 remote frame count n-1
	task wait_for(input int sel);
		for (int i = 0; i < 2000; i++) begin
			if (sel == 0 && receive_complete_flag === 1'b1) return;
			if (sel == 1 && transmit_buffer_empty_flag === 1'b1) return;
			if (sel > 1 && rem_u.frames == sel - 1) return;
			tick(1);
		end
		fail_count++;
		$display("MISMATCH t=%0t wait ran out", $time);
		test_done();
	endtask
	task rd;
		receive_data_read = 1'b1;
		tick(1);
		receive_data_read = 1'b0;
	endtask
	task wr(input logic [7:0] d);
		transmit_data_register = d;
		transmit_write = 1'b1;
		tick(1);
		transmit_write = 1'b0;
	endtask
	task rx_check(input logic [8:0] d, input logic nine);
		rem_u.send(d, nine, 1'b1);
		wait_for(0);
		chk({receive_ninth_bit, receive_data_register}, d);
		rd();
	endtask
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		{high_speed_baud_select, wide_divisor_mode} = 2'b11;
		baud_divisor_high = 8'h00;
		baud_divisor_low = 8'h03;
		transmit_data_register = 8'h00;
		{serial_port_enable, nine_bit_receive_enable, auto_wake_enable,
		 continuous_receive_enable, address_detect_enable, receive_irq_enable,
		 receive_irq_priority, global_irq_enable, peripheral_irq_enable,
		 receive_data_read, transmit_enable_bit, send_break_set, transmit_write,
		 transmit_ninth_bit, nine_bit_transmit_enable} = 15'h0000;
		tick(5);
		rst = 1'b0;
		tick(1);
		chk(tx_pin, 1'b1);
		chk(transmit_buffer_empty_flag, 1'b1);
		chk(shift_register_empty, 1'b1);
		{serial_port_enable, continuous_receive_enable} = 2'b11;
		{receive_irq_enable, global_irq_enable, peripheral_irq_enable} = 3'h7;
		receive_irq_priority = 1'b1;
		rem_u.send(9'h0a5, 1'b0, 1'b1);
		wait_for(0);
		chk(receive_data_register, 8'ha5);
		chk({framing_error, overrun_error}, 2'b00);
		chk({receive_irq_high, receive_irq_low}, 2'b10);
		global_irq_enable = 1'b0;
		tick(1);
		chk({receive_irq_high, receive_irq_low}, 2'b00);
		global_irq_enable = 1'b1;
		receive_irq_priority = 1'b0;
		tick(1);
		chk({receive_irq_high, receive_irq_low}, 2'b01);
		rd();
		chk(receive_complete_flag, 1'b0);
		nine_bit_receive_enable = 1'b1;
		rx_check(9'h13c, 1'b1);
		address_detect_enable = 1'b1;
		rem_u.send(9'h077, 1'b1, 1'b1);
		chk(receive_complete_flag, 1'b0);
		rx_check(9'h1a2, 1'b1);
		address_detect_enable = 1'b0;
		rx_check(9'h044, 1'b1);
		nine_bit_receive_enable = 1'b0;
		rem_u.send(9'h0ff, 1'b0, 1'b0);
		wait_for(0);
		chk(framing_error, 1'b1);
		// a second byte before the read overruns and keeps the first
		rem_u.send(9'h011, 1'b0, 1'b1);
		chk({overrun_error, receive_data_register}, 9'h1ff);
		rd();
		continuous_receive_enable = 1'b0;
		tick(2);
		chk({framing_error, overrun_error}, 2'b00);
		continuous_receive_enable = 1'b1;
		// a break at two-thirds of the rate reads as a zero byte
		baud_divisor_low = 8'h05;
		repeat (13) rem_u.bit_out(1'b0);
		rem_u.bit_out(1'b1);
		wait_for(0);
		chk({framing_error, receive_data_register}, 9'h000);
		rd();
		// normal rate back, as rate detection after the break would set
		baud_divisor_low = 8'h03;
		// auto-wake: two line edges raise the flag, then a byte follows
		auto_wake_enable = 1'b1;
		tick(2);
		rem_u.bit_out(1'b0);
		rem_u.bit_out(1'b1);
		chk(receive_complete_flag, 1'b1);
		chk(receive_data_register, 8'h00);
		rd();
		rx_check(9'h03c, 1'b0);
		auto_wake_enable = 1'b0;
		transmit_enable_bit = 1'b1;
		send_break_set = 1'b1;
		tick(1);
		send_break_set = 1'b0;
		chk(send_break_request, 1'b1);
		wr(8'hff);
		tick(3);
		chk(shift_register_empty, 1'b0);
		wait_for(1);
		{nine_bit_transmit_enable, transmit_ninth_bit} = 2'b11;
		wr(8'h55);
		chk(transmit_buffer_empty_flag, 1'b0);
		wait_for(2);
		chk(9'(rem_u.lows), 9'd13);
		chk(rem_u.got_byte, 8'h00);
		wait_for(3);
		chk(send_break_request, 1'b0);
		chk(rem_u.got_byte, 8'h55);
		chk(9'(rem_u.lows), 9'd1);
		chk(transmit_buffer_empty_flag, 1'b1);
		// an eight-bit frame after the nine-bit one
		nine_bit_transmit_enable = 1'b0;
		wr(8'h3a);
		wait_for(4);
		chk(rem_u.got_byte, 8'h3a);
		chk(9'(rem_u.lows), 9'd2);
		tick(3 * BIT);
		chk({shift_register_empty, tx_pin}, 2'b11);
		test_done();
	end
endmodule
